// >>> src/serial_wake_params.svh
// Purpose: register offsets, field positions, reset values and counts
// Assumes: byte addresses on a 32-bit APB, one register per aligned word
// Notes: definitions only; included by the clock generator, the serial unit and the bench
// Notes on behaviour
// - wake enable only in async station format
// - while waking, frames without station bit discarded, no flags, no irqs
// - station frame sets flag, hardware clears wake
// - tx-end request at MSB with holding empty
// - tx-end withdrawn by empty clear or enable clear
// - async internal, no output: pin neither read nor driven
// - async internal with output: bit-rate clock driven
// - async external: pin clock is sixteen per bit
// - clock output bit ignored in sync or external
// - sync: drive clock if internal, else accept it
// - holding empty set on load or transmitter disable
`ifndef SERIAL_WAKE_PARAMS_SVH
`define SERIAL_WAKE_PARAMS_SVH
// register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_MODE 8'h04
`define ADDR_STAT 8'h08
`define ADDR_TXD 8'h0c
`define ADDR_RXD 8'h10
`define ADDR_IRQ_STAT 8'h14
`define ADDR_IRQ_MASK 8'h18
`define ADDR_BAUD 8'h1c
// control register fields
`define C_TX_EMPTY_IE 7
`define C_RX_IE 6
`define C_TX_EN 5
`define C_RX_EN 4
`define C_WAKE 3
`define C_TX_END_IE 2
`define C_CLK_EXT 1
`define C_CLK_OUT 0
// mode register fields
`define M_SYNC 7
`define M_STATION 2
// status register fields
`define S_TX_EMPTY 7
`define S_RX_FULL 6
`define S_OVERRUN 5
`define S_FRAME_ERR 4
`define S_TX_END 2
`define S_STN 1
`define S_STN_TX 0
`define STAT_CLR_MASK 8'hf0
// interrupt status and mask fields
`define I_RX_FULL 0
`define I_RX_ERR 1
`define I_TX_EMPTY 2
`define I_TX_END 3
`define IRQ_W 4
// reset values
`define CTRL_RESET 8'h00
`define MODE_RESET 8'h00
`define STAT_RESET 8'h84
`define BAUD_RESET 16'h0035
// oversampling: last tick index, centre tick index; then last bit indices and the index before the MSB
`define OS_LAST 4'hf
`define OS_MID 4'h7
`define SYNC_LAST_BIT 4'h7
`define STN_LAST_BIT 4'h8
`define MSB_PREV_BIT 4'h6
`endif

// >>> src/serial_wake_pkg.sv
// Purpose: shared types of the serial unit
// Assumes: constants live in serial_wake_params.svh
// Notes: frame states run in Gray order idle-start-data-stop
`default_nettype none
package serial_wake_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b11,
    ST_STOP = 2'b10
  } frame_state_t;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// >>> src/bit_sync2.sv
// Purpose: two flip-flop synchroniser for levels from outside the clock
// Assumes: inputs change slowly against clk_i
// Notes: first stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module bit_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // next values of both stages
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

// >>> src/serial_clock_gen.sv
// Purpose: oversample and synchronous shift/sample enables, clock out
// Assumes: sck_sync_i already passed two flip-flops
// Notes: internal clock is a free running divider of clk_i
`timescale 1ns/10ps
`default_nettype none
`include "serial_wake_params.svh"
module serial_clock_gen #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // configuration
  input wire logic sync_mode_i,
  input wire logic clk_ext_i,
  input wire logic [DIV_W-1:0] div_i,
  // pin clock, synchronised
  input wire logic sck_sync_i,
  // enables and bit-rate clock level
  output logic os_tick_o,
  output logic shift_tick_o,
  output logic sample_tick_o,
  output logic sck_level_o
);
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [3:0] ph_q;
  logic [3:0] ph_d;
  logic sck_prev_q;
  logic int_tick;
  logic ext_rise;
  logic ext_fall;

  // divider and bit phase; the phase counter gives the bit-rate clock
  always_comb begin
    // >= so a divisor lowered mid-count acts at once instead of after a wrap
    int_tick = (div_q >= div_i);
    div_d = int_tick ? '0 : div_q + 1'b1;
    ph_d = int_tick ? ph_q + 4'h1 : ph_q;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      div_q <= '0;
      ph_q <= 4'h0;
      sck_prev_q <= 1'b1;
    end else begin
      div_q <= div_d;
      ph_q <= ph_d;
      sck_prev_q <= sck_sync_i;
    end
  end

  // edges of the pin clock, found by the own clock
  assign ext_rise = sck_sync_i & ~sck_prev_q;
  assign ext_fall = ~sck_sync_i & sck_prev_q;
  // external async: every pin rising edge is one sixteenth of a bit
  assign os_tick_o = clk_ext_i ? ext_rise : int_tick;
  // sync only: shift on the falling edge, sample on the rising edge
  assign shift_tick_o = sync_mode_i & (clk_ext_i ? ext_fall : (int_tick & (ph_q == `OS_LAST)));
  assign sample_tick_o = sync_mode_i & (clk_ext_i ? ext_rise : (int_tick & (ph_q == `OS_MID)));
  // one period per sixteen oversample ticks, so it runs at the bit rate
  assign sck_level_o = ph_q[3];
endmodule
`default_nettype wire

// >>> src/serial_wake_txend_clock_select.sv
// Purpose: serial unit with station wake-up, tx-end request, clock select
// Assumes: APB slave, no wait states; pin inputs are asynchronous
// Notes: async frame is start, 8 data, optional station bit, one stop
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "serial_wake_params.svh"
module serial_wake_txend_clock_select #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // serial line and clock pin
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  // interrupt requests
  output logic irq_o,
  output logic tx_end_irq_o
);
  import serial_wake_pkg::*;

  logic [7:0] ctrl_q, ctrl_d, mode_q, mode_d, stat_q, stat_d, seen_q, seen_d;
  serial_wake_pkg::byte_t txh_q, txh_d, rxh_q, rxh_d;
  logic [DIV_W-1:0] baud_q, baud_d;
  logic [`IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, ireq_q, ireq;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic rxd_s, sck_s, os_tick, shift_tick, sample_tick, sck_level;
  logic sync_mode, wake_eff, acc, wr, rd;
  logic [7:0] clr;

  frame_state_t tx_st_q, tx_st_d;
  logic [3:0] tx_os_q, tx_os_d, tx_bit_q, tx_bit_d;
  logic [8:0] tx_sh_q, tx_sh_d;
  logic txd_q, txd_d, tx_load, tx_msb_start, tx_adv, tx_go;
  logic [3:0] tx_last, rx_last;

  frame_state_t rx_st_q, rx_st_d;
  logic [3:0] rx_os_q, rx_os_d, rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic rx_stn_q, rx_stn_d, rx_done, rx_stop_ok, rx_blocked;

  // pin inputs pass two flip-flops; line idles high
  bit_sync2 #(.W(2), .INIT(2'b11)) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({rxd_i, sck_i}),
    .sync_o({rxd_s, sck_s})
  );

  serial_clock_gen #(.DIV_W(DIV_W)) u_clk (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .sync_mode_i(sync_mode),
    .clk_ext_i(ctrl_q[`C_CLK_EXT]),
    .div_i(baud_q),
    .sck_sync_i(sck_s),
    .os_tick_o(os_tick),
    .shift_tick_o(shift_tick),
    .sample_tick_o(sample_tick),
    .sck_level_o(sck_level)
  );

  assign sync_mode = mode_q[`M_SYNC];
  // wake bit only counts in async mode with station format
  assign wake_eff = ctrl_q[`C_WAKE] & mode_q[`M_STATION] & ~sync_mode;
  // clock pin: driven only when internal and (sync or output bit)
  assign sck_oe_o = ~ctrl_q[`C_CLK_EXT] & (sync_mode | ctrl_q[`C_CLK_OUT]);
  assign sck_o = sck_level;
  assign txd_o = txd_q;
  // last bit index: station bit follows the data only in async station format
  assign tx_last = (mode_q[`M_STATION] & ~sync_mode) ? `STN_LAST_BIT : `SYNC_LAST_BIT;
  assign rx_last = tx_last;

  // transmitter: next state
  always_comb begin
    tx_st_d = tx_st_q;
    tx_os_d = tx_os_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    txd_d = txd_q;
    tx_load = 1'b0;
    tx_msb_start = 1'b0;
    tx_adv = sync_mode ? shift_tick : (os_tick & (tx_os_q == `OS_LAST));
    tx_go = sync_mode ? shift_tick : os_tick;
    if (os_tick && !sync_mode) begin
      tx_os_d = tx_os_q + 4'h1;
    end
    case (tx_st_q)
      ST_IDLE: begin
        txd_d = 1'b1;
        tx_os_d = 4'h0;
        if (tx_go && ctrl_q[`C_TX_EN] && !stat_q[`S_TX_EMPTY]) begin
          tx_load = 1'b1;
          tx_sh_d = {stat_q[`S_STN_TX], txh_q};
          tx_bit_d = 4'h0;
          tx_st_d = sync_mode ? ST_DATA : ST_START;
          txd_d = sync_mode ? txh_q[0] : 1'b0;
        end
      end
      ST_START: begin
        if (tx_adv) begin
          tx_st_d = ST_DATA;
          txd_d = tx_sh_q[0];
        end
      end
      ST_DATA: begin
        if (tx_adv) begin
          if (tx_bit_q == tx_last) begin
            tx_st_d = sync_mode ? ST_IDLE : ST_STOP;
            txd_d = 1'b1;
          end else begin
            tx_bit_d = tx_bit_q + 4'h1;
            tx_sh_d = {1'b0, tx_sh_q[8:1]};
            txd_d = tx_sh_q[1];
            tx_msb_start = (tx_bit_q == `MSB_PREV_BIT);
          end
        end
      end
      ST_STOP: begin
        if (tx_adv) begin
          tx_st_d = ST_IDLE;
        end
      end
      default: begin
        tx_st_d = ST_IDLE;
      end
    endcase
    // a disabled transmitter abandons the frame and idles the line
    if (!ctrl_q[`C_TX_EN]) begin
      tx_st_d = ST_IDLE;
      txd_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_st_q <= ST_IDLE;
      tx_os_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h000;
      txd_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_os_q <= tx_os_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      txd_q <= txd_d;
    end
  end

  // receiver: next state; async counts sixteen ticks per bit, samples at centre
  always_comb begin
    rx_st_d = rx_st_q;
    rx_os_d = rx_os_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_stn_d = rx_stn_q;
    rx_done = 1'b0;
    rx_stop_ok = 1'b1;
    // a pending error stops reception until software clears it
    rx_blocked = stat_q[`S_OVERRUN] | stat_q[`S_FRAME_ERR];
    if (os_tick && !sync_mode) begin
      rx_os_d = rx_os_q + 4'h1;
    end
    case (rx_st_q)
      ST_IDLE: begin
        rx_os_d = 4'h0;
        rx_bit_d = 4'h0;
        if (ctrl_q[`C_RX_EN] && !rx_blocked) begin
          if (sync_mode && sample_tick) begin
            rx_sh_d = {rxd_s, rx_sh_q[7:1]};
            rx_stn_d = 1'b0;
            rx_bit_d = 4'h1;
            rx_st_d = ST_DATA;
          end else if (!sync_mode && os_tick && !rxd_s) begin
            rx_st_d = ST_START;
          end
        end
      end
      ST_START: begin
        // half a bit in, the start bit must still be low
        if (os_tick && rx_os_q == `OS_MID) begin
          rx_st_d = rxd_s ? ST_IDLE : ST_DATA;
          rx_os_d = 4'h0;
          rx_stn_d = 1'b0;
        end
      end
      ST_DATA: begin
        if (sync_mode ? sample_tick : (os_tick && rx_os_q == `OS_LAST)) begin
          if (rx_bit_q == `STN_LAST_BIT) begin
            rx_stn_d = rxd_s;
          end else begin
            rx_sh_d = {rxd_s, rx_sh_q[7:1]};
          end
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q == (sync_mode ? `SYNC_LAST_BIT : rx_last)) begin
            rx_st_d = sync_mode ? ST_IDLE : ST_STOP;
            rx_done = sync_mode;
          end
        end
      end
      ST_STOP: begin
        // only the first stop bit is checked
        if (os_tick && rx_os_q == `OS_LAST) begin
          rx_done = 1'b1;
          rx_stop_ok = rxd_s;
          rx_st_d = ST_IDLE;
        end
      end
      default: begin
        rx_st_d = ST_IDLE;
      end
    endcase
    if (!ctrl_q[`C_RX_EN]) begin
      rx_st_d = ST_IDLE;
      rx_done = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_st_q <= ST_IDLE;
      rx_os_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_stn_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_os_q <= rx_os_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_stn_q <= rx_stn_d;
    end
  end

  // APB: data captured in setup, answered in the first access cycle
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i;
  assign rd = acc & ~pwrite_i;
  assign pready_o = acc;
  assign prdata_o = rdata_q;
  assign pslverr_o = acc & err_q;
  // flags cleared by writing 0 only after being read as 1
  assign clr = (wr && paddr_i == `ADDR_STAT) ? (`STAT_CLR_MASK & seen_q & ~pwdata_i[7:0]) : 8'h00;

  // interrupt request levels that feed the sticky status
  always_comb begin
    ireq[`I_RX_FULL] = ctrl_q[`C_RX_IE] & stat_q[`S_RX_FULL] & ~wake_eff;
    ireq[`I_RX_ERR] = ctrl_q[`C_RX_IE] & (stat_q[`S_OVERRUN] | stat_q[`S_FRAME_ERR]);
    ireq[`I_TX_EMPTY] = ctrl_q[`C_TX_EMPTY_IE] & stat_q[`S_TX_EMPTY];
    ireq[`I_TX_END] = tx_end_irq_o;
  end

  // registers and flags: software first, then hardware, so a set wins
  always_comb begin
    ctrl_d = ctrl_q;
    mode_d = mode_q;
    baud_d = baud_q;
    txh_d = txh_q;
    rxh_d = rxh_q;
    imask_d = imask_q;
    stat_d = stat_q & ~clr;
    seen_d = seen_q & ~clr;
    ist_d = ist_q;
    rdata_d = rdata_q;
    err_d = err_q;
    if (wr) begin
      case (paddr_i)
        `ADDR_CTRL: ctrl_d = pwdata_i[7:0];
        `ADDR_MODE: mode_d = pwdata_i[7:0];
        `ADDR_STAT: stat_d[`S_STN_TX] = pwdata_i[`S_STN_TX];
        `ADDR_TXD: txh_d = pwdata_i[7:0];
        `ADDR_IRQ_STAT: ist_d = ist_q & ~pwdata_i[`IRQ_W-1:0];
        `ADDR_IRQ_MASK: imask_d = pwdata_i[`IRQ_W-1:0];
        `ADDR_BAUD: baud_d = pwdata_i[DIV_W-1:0];
        default: ;
      endcase
    end
    // remember what the read returned, so a flag set after setup cannot be cleared unseen
    if (rd && paddr_i == `ADDR_STAT) begin
      seen_d = rdata_q[7:0] & `STAT_CLR_MASK;
    end
    // clearing holding-empty after reading it also ends tx-end
    if (clr[`S_TX_EMPTY]) begin
      stat_d[`S_TX_END] = 1'b0;
    end
    if (tx_load) begin
      stat_d[`S_TX_EMPTY] = 1'b1;
      stat_d[`S_TX_END] = 1'b0;
    end
    // a disabled transmitter keeps holding-empty at 1
    if (!ctrl_d[`C_TX_EN]) begin
      stat_d[`S_TX_EMPTY] = 1'b1;
    end
    // MSB leaving with nothing queued marks the end of transmission
    if (tx_msb_start && stat_q[`S_TX_EMPTY]) begin
      stat_d[`S_TX_END] = 1'b1;
    end
    // frames without the station bit vanish while waking
    if (rx_done && !(wake_eff && !rx_stn_d)) begin
      if (wake_eff) begin
        ctrl_d[`C_WAKE] = 1'b0;
      end
      stat_d[`S_STN] = rx_stn_d;
      if (!rx_stop_ok) begin
        stat_d[`S_FRAME_ERR] = 1'b1;
      end else if (stat_q[`S_RX_FULL]) begin
        stat_d[`S_OVERRUN] = 1'b1;
      end else begin
        rxh_d = rx_sh_d;
        stat_d[`S_RX_FULL] = 1'b1;
      end
    end
    ist_d = ist_d | (ireq & ~ireq_q);
    if (psel_i && !penable_i) begin
      err_d = 1'b0;
      case (paddr_i)
        `ADDR_CTRL: rdata_d = {24'h000000, ctrl_q};
        `ADDR_MODE: rdata_d = {24'h000000, mode_q};
        `ADDR_STAT: rdata_d = {24'h000000, stat_q};
        `ADDR_TXD: rdata_d = {24'h000000, txh_q};
        `ADDR_RXD: rdata_d = {24'h000000, rxh_q};
        `ADDR_IRQ_STAT: rdata_d = {{(32-`IRQ_W){1'b0}}, ist_q};
        `ADDR_IRQ_MASK: rdata_d = {{(32-`IRQ_W){1'b0}}, imask_q};
        `ADDR_BAUD: rdata_d = {{(32-DIV_W){1'b0}}, baud_q};
        default: begin
          rdata_d = 32'h00000000;
          err_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl_q <= `CTRL_RESET;
      mode_q <= `MODE_RESET;
      stat_q <= `STAT_RESET;
      seen_q <= 8'h00;
      baud_q <= DIV_W'(`BAUD_RESET);
      txh_q <= 8'h00;
      rxh_q <= 8'h00;
      ist_q <= '0;
      imask_q <= '0;
      ireq_q <= '0;
      rdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
      stat_q <= stat_d;
      seen_q <= seen_d;
      baud_q <= baud_d;
      txh_q <= txh_d;
      rxh_q <= rxh_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      ireq_q <= ireq;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // level requests; tx-end drops when its enable is cleared
  assign tx_end_irq_o = stat_q[`S_TX_END] & ctrl_q[`C_TX_END_IE];
  assign irq_o = |(ist_q & imask_q);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_WAKE_SCOPE: assert property ((sync_mode || !mode_q[`M_STATION]) |-> !wake_eff)
    else $error("wake enable honoured outside async station format");
  AST_WAKE_DISCARD: assert property (rx_done && wake_eff && !rx_stn_d
      |=> !$rose(stat_q[`S_RX_FULL]) && !$rose(stat_q[`S_FRAME_ERR]) && $stable(rxh_q))
    else $error("frame kept while waking");
  AST_WAKE_RELEASE: assert property (rx_done && wake_eff && rx_stn_d
      |=> !ctrl_q[`C_WAKE] && stat_q[`S_STN])
    else $error("station frame did not end waking");
  AST_TX_END_SET: assert property (tx_msb_start && stat_q[`S_TX_EMPTY]
      && ctrl_q[`C_TX_END_IE] && !wr |=> tx_end_irq_o)
    else $error("tx-end request missing at MSB");
  AST_TX_END_OFF: assert property (wr && paddr_i == `ADDR_CTRL
      && !pwdata_i[`C_TX_END_IE] |=> !tx_end_irq_o)
    else $error("tx-end request stayed after enable clear");
  AST_CLK_ASYNC_IN: assert property (!sync_mode && ctrl_q[1:0] == 2'b00 |-> !sck_oe_o)
    else $error("clock pin driven in async internal mode");
  // settled mode only: the pin level may move only after an oversample tick
  AST_CLK_ASYNC_OUT: assert property (!sync_mode && ctrl_q[1:0] == 2'b01
      && $past(ctrl_q[1:0]) == 2'b01 |-> sck_oe_o && (!$changed(sck_o) || $past(os_tick)))
    else $error("async clock output not driven at the tick rate");
  AST_CLK_EXT: assert property (ctrl_q[`C_CLK_EXT]
      |-> !sck_oe_o && (os_tick == (sck_s && !$past(sck_s))))
    else $error("external clock not taken from pin edges");
  AST_CLK_SYNC: assert property (sync_mode && !ctrl_q[`C_CLK_EXT] |-> sck_oe_o)
    else $error("sync internal clock not driven");
  AST_EMPTY_SET: assert property ((tx_load || $fell(ctrl_q[`C_TX_EN]))
      |=> stat_q[`S_TX_EMPTY])
    else $error("holding-empty not set");
  AST_RX_CENTRE: assert property (rx_st_q == ST_START && os_tick && rx_os_q == `OS_MID
      && !rxd_s && ctrl_q[`C_RX_EN] |=> rx_st_q == ST_DATA && rx_os_q == 4'h0)
    else $error("start bit not checked at centre");
endmodule
`default_nettype wire

// >>> verif/remote_station.sv
// Purpose: remote station that sends async frames on its own serial clock
// Assumes: its clock runs only while run_i is high, then stands still low
// Notes: line idles high between frames; bits change on its clock edges
`timescale 1ns/10ps
`default_nettype none
module remote_station (
  // control from the bench
  input wire logic run_i,
  // line side
  output logic line_o,
  output logic sck_o
);
  initial begin
    line_o = 1'b1;
    sck_o = 1'b0;
  end
  // 125 ns clock, sixteen periods per bit on the line
  always #62.5 sck_o = run_i ? ~sck_o : 1'b0;
  // start, eight bits lsb first, station bit when fmt, one stop
  task automatic send(input logic [7:0] d, input logic stn, input logic fmt);
    logic [10:0] f;
    int n;
    f = {1'b1, stn, d, 1'b0};
    n = fmt ? 11 : 10;
    if (!fmt) begin
      f[9] = 1'b1;
    end
    for (int i = 0; i < n; i++) begin
      line_o = f[i];
      repeat (16) @(posedge sck_o);
    end
    line_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: self-checking bench for the serial unit
// Assumes: baud divisor 0 gives one oversample tick per clock
// Notes: the remote station supplies the external clock and rx frames
`timescale 1ns/10ps
`default_nettype none
`include "serial_wake_params.svh"
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, txd, sck_o, sck_oe, irq, tx_end_irq, stn_line, stn_sck;
  logic run = 1'b0;
  wire logic sck_pin;
  logic [31:0] rd;
  logic err;
  logic [7:0] got;
  logic [3:0] tbl [6];
  realtime r0;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  // the pin shows the unit while it drives, else the station
  assign sck_pin = sck_oe ? sck_o : stn_sck;
  serial_wake_txend_clock_select #(.DIV_W(16)) DUT (.clk_i(clk), .reset_n_i(reset_n),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .rxd_i(stn_line), .txd_o(txd), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_o(sck_oe),
    .irq_o(irq), .tx_end_irq_o(tx_end_irq));
  remote_station stn (.run_i(run), .line_o(stn_line), .sck_o(stn_sck));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // hang guard: three frames and register traffic need about 7000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask
  // one apb transfer; #1 lets the write land before callers look
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string what);
    apb(a, 1'b0, 32'h0);
    check(rd & m, e, what);
  endtask
  initial begin
    tbl = '{4'b0000, 4'b0011, 4'b0110, 4'b1001, 4'b1100, 4'b1110};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    // reset values and an unmapped word
    rdchk(`ADDR_CTRL, 32'hffffffff, 32'h0, "ctrl reset");
    rdchk(`ADDR_STAT, 32'hffffffff, 32'h84, "status reset");
    rdchk(`ADDR_BAUD, 32'hffffffff, 32'h35, "baud reset");
    check(sck_oe, 1'b0, "pin not driven");
    apb(8'h20, 1'b0, 32'h0);
    check(rd, 32'h0, "unmapped data");
    check(err, 1'b1, "unmapped error");
    $display("test registers done");
    // pin direction for six of the eight mode and clock select pairs {sync,ext,out,oe}
    foreach (tbl[i]) begin
      wr(`ADDR_MODE, {24'h0, tbl[i][3], 7'h0});
      wr(`ADDR_CTRL, {30'h0, tbl[i][2:1]});
      check(sck_oe, tbl[i][0], "pin drive");
    end
    wr(`ADDR_MODE, 32'h0);
    wr(`ADDR_BAUD, 32'h0);
    wr(`ADDR_CTRL, 32'h01);
    @(posedge sck_o);
    r0 = $realtime;
    @(posedge sck_o);
    check(int'($realtime - r0), 160, "clock out period");
    $display("test clock select done");
    // station wake-up on the external clock
    run <= 1'b1;
    wr(`ADDR_IRQ_MASK, 32'h01);
    wr(`ADDR_MODE, 32'h04);
    wr(`ADDR_CTRL, 32'h5a);
    stn.send(8'h11, 1'b0, 1'b1);
    repeat (40) @(posedge clk);
    rdchk(`ADDR_STAT, 32'h72, 32'h0, "frame discarded");
    rdchk(`ADDR_CTRL, 32'hff, 32'h5a, "still waking");
    check(irq, 1'b0, "no rx irq");
    stn.send(8'h22, 1'b1, 1'b1);
    repeat (40) @(posedge clk);
    rdchk(`ADDR_STAT, 32'h72, 32'h42, "station frame");
    rdchk(`ADDR_CTRL, 32'hff, 32'h52, "wake cleared");
    rdchk(`ADDR_RXD, 32'hff, 32'h22, "rx data");
    check(irq, 1'b1, "rx irq");
    wr(`ADDR_STAT, 32'h80);
    wr(`ADDR_IRQ_STAT, 32'h01);
    check(irq, 1'b0, "irq cleared");
    // wake bit has no effect without station format
    wr(`ADDR_MODE, 32'h00);
    wr(`ADDR_CTRL, 32'h5a);
    stn.send(8'h33, 1'b0, 1'b0);
    repeat (40) @(posedge clk);
    rdchk(`ADDR_STAT, 32'h40, 32'h40, "wake ignored");
    rdchk(`ADDR_RXD, 32'hff, 32'h33, "plain frame");
    run <= 1'b0;
    $display("test wake done");
    // one byte out on the internal clock, tx-end at its last bit
    wr(`ADDR_IRQ_MASK, 32'h08);
    wr(`ADDR_CTRL, 32'h24);
    wr(`ADDR_TXD, 32'h55);
    rdchk(`ADDR_STAT, 32'h80, 32'h80, "empty before load");
    // drop the sticky tx-end left by enabling it while the old flag stood
    wr(`ADDR_IRQ_STAT, 32'h08);
    wr(`ADDR_STAT, 32'h00);
    while (txd !== 1'b0) @(posedge clk);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk);
      got[i] = txd;
      if (i == 6) begin
        check(tx_end_irq, 1'b0, "no tx end before msb");
        check(irq, 1'b0, "no tx irq before msb");
      end
    end
    check(got, 8'h55, "tx byte");
    check(tx_end_irq, 1'b1, "tx end at msb");
    rdchk(`ADDR_STAT, 32'h84, 32'h84, "loaded and ended");
    check(irq, 1'b1, "tx end irq line");
    wr(`ADDR_CTRL, 32'h20);
    check(tx_end_irq, 1'b0, "withdrawn by enable");
    wr(`ADDR_CTRL, 32'h24);
    check(tx_end_irq, 1'b1, "request back");
    wr(`ADDR_STAT, 32'h00);
    check(tx_end_irq, 1'b0, "withdrawn by empty clear");
    wr(`ADDR_IRQ_STAT, 32'h08);
    check(irq, 1'b0, "tx irq cleared");
    $display("test transmit done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
